// ---- common/crpf_consts.svh ----
// constant values of the cpu reset and pin float controller
`ifndef CRPF_CONSTS_SVH
`define CRPF_CONSTS_SVH

// register byte offsets on the wishbone slave
`define CRPF_ADR_WDCTL 12'h000
`define CRPF_ADR_WDSEL 12'h004
`define CRPF_ADR_TRIM 12'h008
`define CRPF_ADR_PORTS 12'h00C
`define CRPF_ADR_CPU 12'h010
`define CRPF_ADR_STAT 12'h014
`define CRPF_ADR_RAM_BASE 12'h400
`define CRPF_ADR_RAM_TOP 12'h7FC

// bit positions in watchdog_control_reg
`define CRPF_BIT_WD_CLEAR 0
`define CRPF_BIT_WD_ENABLE 1
`define CRPF_BIT_WD_FLAG 2
`define CRPF_BIT_POR_FLAG 6

// bit positions in the cpu control register
`define CRPF_BIT_IRQ_EN 0
`define CRPF_BIT_TMR_EN 1
`define CRPF_BIT_STOP 2

// reset values
`define CRPF_RST_VECTOR 16'h0000
`define CRPF_RST_PORTS 32'hFFFFFFFF
`define CRPF_RST_SP 8'h00
`define CRPF_RST_WDSEL 2'h0
`define CRPF_TRIM_NOBAT 8'h65

// timing counts, in clocks or machine cycles
`define CRPF_MC_CLKS 4
`define CRPF_HOLD_MC 2
`define CRPF_DETECT_MC 2
`define CRPF_FLOAT_MC 2
`define CRPF_POR_CLKS 65536
`define CRPF_WD_BASE_CLKS 131072

`endif

// ---- common/crpf_pkg.sv ----
// types of the cpu reset and pin float controller
package crpf_pkg;

    // sequencer states, gray steps along por -> run -> hold -> exit
    typedef enum logic [2:0] {
        ST_POR = 3'h0,
        ST_RUN = 3'h1,
        ST_HOLD = 3'h3,
        ST_EXIT = 3'h2,
        ST_ARM = 3'h6,
        ST_FLOAT = 3'h7,
        ST_STOP = 3'h5,
        ST_WDT = 3'h4
    } crpf_state_e;

    // classic wishbone request from the master
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [11:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } crpf_wb_req_s;

    // state of the top module, all but the scratchpad ram and the pin synchronisers
    typedef struct packed {
        crpf_state_e st;
        logic [3:0] mc_div;
        logic [1:0] mc_cnt;
        logic [1:0] hi_cnt;
        logic [23:0] delay_cnt;
        logic [31:0] wd_cnt;
        logic por_flag;
        logic wd_flag;
        logic wd_enable;
        logic [1:0] wd_sel;
        logic irq_en;
        logic tmr_en;
        logic [7:0] sp;
        logic [31:0] ports;
        logic [7:0] trim;
        logic test_mode;
        logic cpu_reset;
        logic fetch_en;
        logic pc_load;
        logic [15:0] pc_vec;
        logic osc_en;
        logic pins_float;
        logic port_oe;
        logic wb_pend;
        logic wb_ack;
        logic [31:0] wb_dat;
    } crpf_state_s;

endpackage : crpf_pkg

// ---- test/crpf_asserts.sv ----
// checker of the reset sequencer outputs
`timescale 1ns/1ns
`default_nettype none

module crpf_asserts (
    // watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ext_reset_pin_i,
    input wire logic cpu_reset_o,
    input wire logic fetch_en_o,
    input wire logic pc_load_o,
    input wire logic [15:0] pc_vec_o,
    input wire logic osc_en_o,
    input wire logic irq_en_o,
    input wire logic tmr_en_o,
    input wire logic [7:0] sp_o,
    input wire logic [1:0] wd_sel_o,
    input wire logic [31:0] port_o,
    input wire logic port_oe_o,
    input wire logic pins_float_o,
    input wire logic strobe_pullup_o
);
    // ********
    // properties
    // ********
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // a reset never lets the core fetch
    chk_no_fetch: assert property (cpu_reset_o |-> !fetch_en_o)
        else $error("fetch during reset");
    chk_vec_zero: assert property (pc_load_o |-> pc_vec_o == 16'h0000)
        else $error("restart vector wrong");
    chk_run_state: assert property (pc_load_o |-> {sp_o, irq_en_o, tmr_en_o, wd_sel_o} == 12'h000)
        else $error("reset state not restored");
    chk_ports_high: assert property (pc_load_o |-> port_o == 32'hFFFFFFFF)
        else $error("port latches not high");
    chk_float_pins: assert property (pins_float_o |-> !port_oe_o && strobe_pullup_o)
        else $error("float pins wrong");
    chk_float_osc: assert property (pins_float_o |-> osc_en_o)
        else $error("oscillator off in float");
    // worst detection is sync plus two ticks, well inside sixteen clocks
    chk_pin_hold: assert property (ext_reset_pin_i [*8] ##1 ext_reset_pin_i [*8] |-> cpu_reset_o)
        else $error("pin high but core runs");
    chk_stop_wake: assert property (!osc_en_o && ext_reset_pin_i ##1 ext_reset_pin_i [*6] |-> osc_en_o)
        else $error("oscillator not restarted");

    // main scenarios
    cover property (pc_load_o);
    cover property (pins_float_o);
    cover property (!osc_en_o ##1 osc_en_o);
endmodule : crpf_asserts
`default_nettype wire

// ---- test/crpf_board.sv ----
// board model driving the reset pin, strobes and port 2 pins
`timescale 1ns/1ns
`default_nettype none

module crpf_board (
    // clock and requests
    input wire logic clk_i,
    input wire logic pin_req_i,
    input wire logic float_req_i,
    input wire logic [2:0] p2_req_i,
    // board pins
    output logic ext_pin_o = 1'b0,
    output logic ale_o = 1'b1,
    output logic program_store_strobe_o = 1'b0,
    output logic [2:0] p2_o = 3'h7
);
    // ********
    // pins
    // ********
    // pins move just after an edge; strobes stay put while float is asked
    always @(posedge clk_i) begin
        ext_pin_o <= pin_req_i;
        ale_o <= !float_req_i;
        program_store_strobe_o <= float_req_i;
        p2_o <= p2_req_i;
    end
endmodule : crpf_board
`default_nettype wire

// ---- test/crpf_top_bench.sv ----
// self-checking bench of the reset sequencer
`timescale 1ns/1ns
`default_nettype none
`include "crpf_consts.svh"

module crpf_top_bench;
    // ********
    // harness
    // ********
    localparam int MC = 4;
    localparam int POR = 64;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bat = 1'b0;
    logic pin_req = 1'b0;
    logic float_req = 1'b0;
    logic [2:0] p2_req = 3'h7;
    crpf_pkg::crpf_wb_req_s wb_req = '0;
    logic wb_ack_o, ext_pin, ale, program_store_strobe, cpu_reset_o, fetch_en_o, pc_load_o, osc_en_o;
    logic irq_en_o, tmr_en_o, test_mode_o, port_oe_o, pins_float_o, strobe_pullup_o;
    logic [2:0] p2;
    logic [1:0] wd_sel_o;
    logic [7:0] sp_o, trim_o;
    logic [15:0] pc_vec_o;
    logic [31:0] wb_dat_o, port_o, rd;
    int mismatches = 0;
    int compares = 0;
    int waited;

    crpf_board crpf_board_inst (.clk_i, .pin_req_i(pin_req), .float_req_i(float_req),
        .p2_req_i(p2_req), .ext_pin_o(ext_pin), .ale_o(ale), .program_store_strobe_o(program_store_strobe), .p2_o(p2));
    // short counts keep the run brief
    crpf_top #(.MC_CLKS(MC), .POR_CLKS(POR), .WD_BASE_CLKS(64)) crpf_top_inst (.clk_i, .rst_i,
        .wb_req_i(wb_req), .wb_ack_o, .wb_dat_o, .ext_reset_pin_i(ext_pin), .ale_i(ale),
        .program_store_strobe_i(program_store_strobe), .p2_hi_i(p2), .battery_ok_i(bat), .cpu_reset_o, .fetch_en_o,
        .pc_load_o, .pc_vec_o, .osc_en_o, .irq_en_o, .tmr_en_o, .sp_o, .wd_sel_o, .trim_o,
        .test_mode_o, .port_o, .port_oe_o, .pins_float_o, .strobe_pullup_o);

    // clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask : tick

    // one classic cycle; request held until ack is sampled
    task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
        waited = 0;
        do begin
            @(posedge clk_i);
            waited++;
        end while (wb_ack_o !== 1'b1 && waited < 50);
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
            test_done();
        end
        rd = wb_dat_o;
        wb_req <= '0;
        @(posedge clk_i);
    endtask : wb

    task automatic wait_rst(input logic v, input int n);
        waited = 0;
        while (cpu_reset_o !== v) begin
            @(posedge clk_i);
            waited++;
            if (waited > n) begin
                mismatches++;
                test_done();
            end
        end
    endtask : wait_rst

    task automatic pulse();
        pin_req <= 1'b1;
        tick(4 * MC);
        pin_req <= 1'b0;
        wait_rst(1'b0, 6 * MC);
    endtask : pulse

    // ********
    // scenarios
    // ********
    task automatic power_cycle();
        wait_rst(1'b0, 200);
        chk("por delay", 32'(waited >= POR), 32'h1);
        wb(1'b0, `CRPF_ADR_WDCTL, 32'h0);
        chk("cause flags", rd & 32'h44, 32'h40);
        chk("trim", {24'h0, trim_o}, 32'h65);
        wb(1'b0, 12'h100, 32'h0);
        chk("unmapped", rd, 32'h0);
        bat <= 1'b1;
        tick(4);
        wb(1'b1, `CRPF_ADR_TRIM, 32'h12);
        rst_i <= 1'b1;
        tick(3);
        rst_i <= 1'b0;
        wait_rst(1'b0, 200);
        chk("trim kept", {24'h0, trim_o}, 32'h12);
        bat <= 1'b0;
        tick(4);
        chk("trim lost", {24'h0, trim_o}, 32'h65);
    endtask : power_cycle

    task automatic ext_reset();
        wb(1'b1, `CRPF_ADR_RAM_BASE, 32'hA5);
        wb(1'b1, `CRPF_ADR_CPU, 32'h3303);
        wb(1'b1, `CRPF_ADR_WDSEL, 32'h3);
        wb(1'b1, `CRPF_ADR_PORTS, 32'h0);
        wb(1'b1, `CRPF_ADR_WDCTL, 32'h0);
        pin_req <= 1'b1;
        wait_rst(1'b1, 20);
        tick(2 * MC);
        chk("ports", port_o, 32'hFFFFFFFF);
        tick(20);
        chk("held", {31'h0, cpu_reset_o}, 32'h1);
        pin_req <= 1'b0;
        wait_rst(1'b0, 16);
        chk("regs", {20'h0, sp_o, irq_en_o, tmr_en_o, wd_sel_o}, 32'h0);
        wb(1'b0, `CRPF_ADR_WDCTL, 32'h0);
        chk("no cause", rd & 32'h44, 32'h0);
        wb(1'b0, `CRPF_ADR_RAM_BASE, 32'h0);
        chk("ram", rd & 32'hFF, 32'hA5);
    endtask : ext_reset

    task automatic wd_reset();
        wb(1'b1, `CRPF_ADR_WDCTL, 32'h2);
        wait_rst(1'b1, 400);
        wait_rst(1'b0, 4 * MC);
        chk("wd hold", 32'(waited > MC && waited <= 2 * MC), 32'h1);
        wb(1'b0, `CRPF_ADR_WDCTL, 32'h0);
        chk("wd flag", rd & 32'h44, 32'h04);
        wb(1'b1, `CRPF_ADR_WDCTL, 32'h0);
    endtask : wd_reset

    task automatic stop_wake();
        wb(1'b1, `CRPF_ADR_CPU, 32'h4);
        tick(2);
        chk("osc stop", {31'h0, osc_en_o}, 32'h0);
        pin_req <= 1'b1;
        tick(2 * MC);
        chk("osc wake", {31'h0, osc_en_o}, 32'h1);
        pin_req <= 1'b0;
        wait_rst(1'b0, 200);
        chk("wake delay", 32'(waited >= POR - 2 * MC), 32'h1);
    endtask : stop_wake

    task automatic float_mode();
        pin_req <= 1'b1;
        float_req <= 1'b1;
        wait_rst(1'b1, 20);
        tick(20);
        pin_req <= 1'b0;
        tick(4 * MC);
        chk("float", {28'h0, pins_float_o, strobe_pullup_o, port_oe_o, osc_en_o}, 32'hD);
        float_req <= 1'b0;
        tick(4 * MC);
        chk("strobes", {31'h0, pins_float_o}, 32'h1);
        pulse();
        chk("float exit", {30'h0, pins_float_o, fetch_en_o}, 32'h1);
    endtask : float_mode

    task automatic test_mode();
        p2_req <= 3'h6;
        pulse();
        chk("test", {30'h0, test_mode_o, fetch_en_o}, 32'h2);
        p2_req <= 3'h7;
        tick(8);
        chk("test kept", {30'h0, test_mode_o, fetch_en_o}, 32'h2);
        pulse();
        chk("test off", {30'h0, test_mode_o, fetch_en_o}, 32'h1);
    endtask : test_mode

    // main sequence
    initial begin
        tick(10);
        rst_i <= 1'b0;
        power_cycle();
        ext_reset();
        wd_reset();
        stop_wake();
        float_mode();
        test_mode();
        test_done();
    end
endmodule : crpf_top_bench

bind crpf_top crpf_asserts crpf_asserts_inst (.clk_i, .rst_i, .ext_reset_pin_i, .cpu_reset_o,
    .fetch_en_o, .pc_load_o, .pc_vec_o, .osc_en_o, .irq_en_o, .tmr_en_o, .sp_o, .wd_sel_o,
    .port_o, .port_oe_o, .pins_float_o, .strobe_pullup_o);
`default_nettype wire

// ---- verilog/crpf_ram.sv ----
// scratchpad ram with registered read data, never cleared by reset
`timescale 1ns/1ns
`default_nettype none

module crpf_ram #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    // clock
    input wire logic clk_i,
    // access port
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset on purpose: contents survive every reset source
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem[addr_i] <= wdata_i;
        end
        rdata_o <= mem[addr_i];
    end

endmodule : crpf_ram

`default_nettype wire

// ---- verilog/crpf_sync2.sv ----
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module crpf_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [1:0][WIDTH-1:0] stage;
    logic [1:0][WIDTH-1:0] next_stage;

    // first stage feeds only the second stage
    always_comb begin
        next_stage[0] = d_i;
        next_stage[1] = stage[0];
    end

    // no reset: a cleared stage would fake a battery loss after every reset
    always_ff @(posedge clk_i) begin
        stage <= next_stage;
    end

    assign q_o = stage[1];

endmodule : crpf_sync2

`default_nettype wire

// ---- verilog/crpf_top.sv ----
// cpu reset sequencer with cause flags, reset state and pin float entry
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "crpf_consts.svh"

module crpf_top #(
    parameter int MC_CLKS = `CRPF_MC_CLKS,
    parameter int POR_CLKS = `CRPF_POR_CLKS,
    parameter int WD_BASE_CLKS = `CRPF_WD_BASE_CLKS
) (
    // clock and power-on reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire crpf_pkg::crpf_wb_req_s wb_req_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    // board pins, asynchronous
    input wire logic ext_reset_pin_i,
    input wire logic ale_i,
    input wire logic program_store_strobe_i,
    input wire logic [2:0] p2_hi_i,
    input wire logic battery_ok_i,
    // cpu core control
    output logic cpu_reset_o,
    output logic fetch_en_o,
    output logic pc_load_o,
    output logic [15:0] pc_vec_o,
    output logic osc_en_o,
    output logic irq_en_o,
    output logic tmr_en_o,
    output logic [7:0] sp_o,
    output logic [1:0] wd_sel_o,
    output logic [7:0] trim_o,
    output logic test_mode_o,
    // pin drivers
    output logic [31:0] port_o,
    output logic port_oe_o,
    output logic pins_float_o,
    output logic strobe_pullup_o
);

    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (MC_CLKS < 2 || MC_CLKS > 15) begin : g_bad_mc
        $error("MC_CLKS must lie in 2..15");
    end
    if (POR_CLKS < 2 || POR_CLKS > 16777216) begin : g_bad_por
        $error("POR_CLKS must lie in 2..2**24");
    end
    if (WD_BASE_CLKS < 2 || WD_BASE_CLKS > 67108863) begin : g_bad_wd
        $error("WD_BASE_CLKS must lie in 2..2**26-1");
    end

    localparam logic [3:0] MC_LAST = 4'(MC_CLKS - 1);
    localparam logic [23:0] POR_LAST = 24'(POR_CLKS - 1);
    localparam logic [31:0] WD_BASE = 32'(WD_BASE_CLKS);
    localparam logic [1:0] HOLD_LAST = 2'(`CRPF_HOLD_MC - 1);
    localparam logic [1:0] DET_LAST = 2'(`CRPF_DETECT_MC - 1);
    localparam logic [1:0] FLOAT_LAST = 2'(`CRPF_FLOAT_MC - 1);

    // ****************************************************************
    // pin synchronisers and scratchpad
    // ****************************************************************
    logic [6:0] pins_s;
    logic pin_rst;
    logic ale_s;
    logic program_store_strobe_s;
    logic [2:0] p2_s;
    logic bat_ok;
    logic [7:0] ram_q;
    logic ram_hit;
    logic ram_we;

    // every board level crosses two flip-flops first
    crpf_sync2 #(.WIDTH(7)) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({battery_ok_i, p2_hi_i, program_store_strobe_i, ale_i, ext_reset_pin_i}),
        .q_o(pins_s)
    );

    assign pin_rst = pins_s[0];
    assign ale_s = pins_s[1];
    assign program_store_strobe_s = pins_s[2];
    assign p2_s = pins_s[5:3];
    assign bat_ok = pins_s[6];

    crpf_pkg::crpf_state_s q;
    crpf_pkg::crpf_state_s next_q;

    // ram sits outside the state record so no reset can reach it
    assign ram_hit = wb_req_i.adr >= `CRPF_ADR_RAM_BASE && wb_req_i.adr <= `CRPF_ADR_RAM_TOP;
    assign ram_we = q.wb_pend && wb_req_i.we && ram_hit && wb_req_i.sel[0];

    crpf_ram #(.AW(8), .DW(8)) u_ram (
        .clk_i(clk_i),
        .we_i(ram_we),
        .addr_i(wb_req_i.adr[9:2]),
        .wdata_i(wb_req_i.dat[7:0]),
        .rdata_o(ram_q)
    );

    // ****************************************************************
    // register reinitialisation shared by every reset source
    // ****************************************************************
    function automatic crpf_pkg::crpf_state_s reinit(input crpf_pkg::crpf_state_s s);
        crpf_pkg::crpf_state_s r;
        r = s;
        r.sp = `CRPF_RST_SP;
        r.irq_en = 1'b0;
        r.tmr_en = 1'b0;
        r.wd_sel = `CRPF_RST_WDSEL;
        r.ports = `CRPF_RST_PORTS;
        r.wd_enable = 1'b0;
        r.wd_cnt = '0;
        r.pc_vec = `CRPF_RST_VECTOR;
        r.mc_cnt = '0;
        r.hi_cnt = '0;
        return r;
    endfunction : reinit

    // ****************************************************************
    // next state
    // ****************************************************************
    logic tick;
    logic stop_req;
    logic wd_clear;
    logic float_cond;
    logic pin_detect;
    logic [31:0] wd_limit;
    logic [31:0] rd;

    always_comb begin
        next_q = q;
        stop_req = 1'b0;
        wd_clear = 1'b0;
        rd = '0;
        next_q.pc_load = 1'b0;
        next_q.wb_ack = 1'b0;
        tick = (q.mc_div == MC_LAST);
        next_q.mc_div = tick ? 4'h0 : q.mc_div + 4'h1;
        float_cond = !ale_s && program_store_strobe_s;
        wd_limit = WD_BASE << {q.wd_sel, 1'b0};

        // bus: take in one cycle, answer with ack in the next
        if (q.wb_pend) begin
            next_q.wb_pend = 1'b0;
            next_q.wb_ack = 1'b1;
            unique case (wb_req_i.adr)
                `CRPF_ADR_WDCTL: begin
                    rd[`CRPF_BIT_POR_FLAG] = q.por_flag;
                    rd[`CRPF_BIT_WD_FLAG] = q.wd_flag;
                    rd[`CRPF_BIT_WD_ENABLE] = q.wd_enable;
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        next_q.wd_enable = wb_req_i.dat[`CRPF_BIT_WD_ENABLE];
                        wd_clear = wb_req_i.dat[`CRPF_BIT_WD_CLEAR];
                        // flags clear by software, and wd_flag also at power-on reset; hardware sets later win
                        if (!wb_req_i.dat[`CRPF_BIT_WD_FLAG]) begin
                            next_q.wd_flag = 1'b0;
                        end
                        if (!wb_req_i.dat[`CRPF_BIT_POR_FLAG]) begin
                            next_q.por_flag = 1'b0;
                        end
                    end
                end
                `CRPF_ADR_WDSEL: begin
                    rd[1:0] = q.wd_sel;
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        next_q.wd_sel = wb_req_i.dat[1:0];
                    end
                end
                `CRPF_ADR_TRIM: begin
                    rd[7:0] = q.trim;
                    // battery backed bits accept writes only with a battery
                    if (wb_req_i.we && wb_req_i.sel[0] && bat_ok) begin
                        next_q.trim = wb_req_i.dat[7:0];
                    end
                end
                `CRPF_ADR_PORTS: begin
                    rd = q.ports;
                    if (wb_req_i.we) begin
                        for (int i = 0; i < 4; i++) begin
                            if (wb_req_i.sel[i]) begin
                                next_q.ports[8*i +: 8] = wb_req_i.dat[8*i +: 8];
                            end
                        end
                    end
                end
                `CRPF_ADR_CPU: begin
                    rd[`CRPF_BIT_IRQ_EN] = q.irq_en;
                    rd[`CRPF_BIT_TMR_EN] = q.tmr_en;
                    rd[15:8] = q.sp;
                    if (wb_req_i.we && wb_req_i.sel[0]) begin
                        next_q.irq_en = wb_req_i.dat[`CRPF_BIT_IRQ_EN];
                        next_q.tmr_en = wb_req_i.dat[`CRPF_BIT_TMR_EN];
                        stop_req = wb_req_i.dat[`CRPF_BIT_STOP];
                    end
                    if (wb_req_i.we && wb_req_i.sel[1]) begin
                        next_q.sp = wb_req_i.dat[15:8];
                    end
                end
                `CRPF_ADR_STAT: begin
                    rd[2:0] = q.st;
                    rd[3] = q.test_mode;
                    rd[4] = q.pins_float;
                    rd[5] = bat_ok;
                end
                default: begin
                    // unmapped addresses read zero and ignore writes
                    rd = ram_hit ? {24'h000000, ram_q} : 32'h00000000;
                end
            endcase
            next_q.wb_dat = rd;
        end else if (wb_req_i.cyc && wb_req_i.stb && !q.wb_ack) begin
            next_q.wb_pend = 1'b1;
        end

        // reset pin must stay high for whole machine cycles
        pin_detect = 1'b0;
        if (!pin_rst) begin
            next_q.hi_cnt = '0;
        end else if (tick) begin
            if (q.hi_cnt == DET_LAST) begin
                pin_detect = 1'b1;
            end else begin
                next_q.hi_cnt = q.hi_cnt + 2'h1;
            end
        end

        unique case (q.st)
            crpf_pkg::ST_POR: begin
                // crystal warm-up before the first fetch
                if (q.delay_cnt == POR_LAST) begin
                    next_q.st = crpf_pkg::ST_RUN;
                    next_q.pc_load = 1'b1;
                end else begin
                    next_q.delay_cnt = q.delay_cnt + 24'h000001;
                end
            end
            crpf_pkg::ST_RUN: begin
                if (pin_detect) begin
                    // external reset leaves cause flags alone
                    next_q = reinit(next_q);
                    next_q.st = crpf_pkg::ST_HOLD;
                end else if (q.wd_enable && q.wd_cnt >= wd_limit - 32'h00000001) begin
                    next_q = reinit(next_q);
                    next_q.wd_flag = 1'b1;
                    next_q.st = crpf_pkg::ST_WDT;
                end else if (stop_req) begin
                    next_q.st = crpf_pkg::ST_STOP;
                end else if (wd_clear || q.wd_cnt >= wd_limit - 32'h00000001) begin
                    // a disabled watchdog restarts without swallowing a stop request
                    next_q.wd_cnt = '0;
                end else begin
                    next_q.wd_cnt = q.wd_cnt + 32'h00000001;
                end
            end
            crpf_pkg::ST_WDT: begin
                if (pin_detect) begin
                    next_q = reinit(next_q);
                    next_q.st = crpf_pkg::ST_HOLD;
                end else if (tick) begin
                    // two machine cycles, then vector
                    if (q.mc_cnt == HOLD_LAST) begin
                        next_q.st = crpf_pkg::ST_RUN;
                        next_q.pc_load = 1'b1;
                    end else begin
                        next_q.mc_cnt = q.mc_cnt + 2'h1;
                    end
                end
            end
            crpf_pkg::ST_HOLD: begin
                // held for as long as the pin stays high
                next_q.ports = `CRPF_RST_PORTS;
                if (!pin_rst) begin
                    // strap sampled once, at the release edge
                    next_q.test_mode = !(&p2_s);
                    next_q.mc_cnt = '0;
                    next_q.st = float_cond ? crpf_pkg::ST_ARM : crpf_pkg::ST_EXIT;
                end
            end
            crpf_pkg::ST_EXIT: begin
                if (pin_rst) begin
                    next_q.st = crpf_pkg::ST_HOLD;
                end else if (tick) begin
                    if (q.mc_cnt == HOLD_LAST) begin
                        next_q.st = crpf_pkg::ST_RUN;
                        next_q.pc_load = 1'b1;
                    end else begin
                        next_q.mc_cnt = q.mc_cnt + 2'h1;
                    end
                end
            end
            crpf_pkg::ST_ARM: begin
                // board holds strobes two machine cycles after release
                if (pin_rst) begin
                    next_q.st = crpf_pkg::ST_HOLD;
                end else if (!float_cond) begin
                    next_q.st = crpf_pkg::ST_EXIT;
                end else if (tick) begin
                    if (q.mc_cnt == FLOAT_LAST) begin
                        next_q.st = crpf_pkg::ST_FLOAT;
                    end else begin
                        next_q.mc_cnt = q.mc_cnt + 2'h1;
                    end
                end
            end
            crpf_pkg::ST_FLOAT: begin
                // strobes no longer looked at, only the reset pin
                if (pin_detect) begin
                    next_q = reinit(next_q);
                    next_q.st = crpf_pkg::ST_HOLD;
                end
            end
            crpf_pkg::ST_STOP: begin
                // no clock edges count in stop, so the pin is seen at once
                if (pin_rst) begin
                    next_q = reinit(next_q);
                    next_q.delay_cnt = '0;
                    next_q.st = crpf_pkg::ST_POR;
                end
            end
            default: begin
                next_q.st = crpf_pkg::ST_POR;
            end
        endcase

        // no battery: bits held at their defaults until one appears
        if (!bat_ok) begin
            next_q.trim = `CRPF_TRIM_NOBAT;
        end

        // power-on reset: the whole state record except battery backed bits
        if (rst_i) begin
            next_q = reinit(next_q);
            next_q.st = crpf_pkg::ST_POR;
            next_q.mc_div = '0;
            next_q.delay_cnt = '0;
            next_q.por_flag = 1'b1;
            next_q.wd_flag = 1'b0;
            next_q.test_mode = 1'b0;
            next_q.pc_load = 1'b0;
            next_q.wb_pend = 1'b0;
            next_q.wb_ack = 1'b0;
            next_q.wb_dat = '0;
            next_q.trim = q.trim;
        end

        // core and pin controls follow the next state
        next_q.cpu_reset = next_q.st != crpf_pkg::ST_RUN;
        next_q.fetch_en = next_q.st == crpf_pkg::ST_RUN && !next_q.test_mode;
        next_q.osc_en = next_q.st != crpf_pkg::ST_STOP;
        next_q.pins_float = next_q.st == crpf_pkg::ST_FLOAT;
        next_q.port_oe = next_q.st != crpf_pkg::ST_FLOAT;
    end

    // single state register
    always_ff @(posedge clk_i) begin
        q <= next_q;
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    assign wb_ack_o = q.wb_ack;
    assign wb_dat_o = q.wb_dat;
    assign cpu_reset_o = q.cpu_reset;
    assign fetch_en_o = q.fetch_en;
    assign pc_load_o = q.pc_load;
    assign pc_vec_o = q.pc_vec;
    assign osc_en_o = q.osc_en;
    assign irq_en_o = q.irq_en;
    assign tmr_en_o = q.tmr_en;
    assign sp_o = q.sp;
    assign wd_sel_o = q.wd_sel;
    assign trim_o = q.trim;
    assign test_mode_o = q.test_mode;
    assign port_o = q.ports;
    assign port_oe_o = q.port_oe;
    assign pins_float_o = q.pins_float;
    assign strobe_pullup_o = q.pins_float; // weak pull-ups only while floating

endmodule : crpf_top

`default_nettype wire
